// ===== logic/irq_bank_pkg.sv
// irq_bank_pkg: register map, field layouts and reset values of the
// interrupt flag and enable bank.
// assumes: 32-bit apb data, each 16-bit register in the low half of a word.
package irq_bank_pkg;

    // ************************************************************
    // register byte offsets
    // ************************************************************
    localparam logic [7:0] OFS_FLAG5      = 8'h00;
    localparam logic [7:0] OFS_ENABLE0    = 8'h04;
    localparam logic [7:0] OFS_ENABLE1    = 8'h08;
    localparam logic [7:0] OFS_ENABLE2    = 8'h0C;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h10;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h14;
    localparam logic [7:0] OFS_REQUEST5   = 8'h18;

    // ************************************************************
    // implemented bits and reset values
    // ************************************************************
    localparam logic [15:0] IMPL_FLAG5   = 16'h3FBE;
    localparam logic [15:0] IMPL_ENABLE0 = 16'h3FEF;
    localparam logic [15:0] IMPL_ENABLE1 = 16'hFEDF;
    localparam logic [15:0] IMPL_ENABLE2 = 16'h3FE3;
    localparam logic [15:0] RESET_REG16  = 16'h0000;

    // ************************************************************
    // bank event status bits
    // ************************************************************
    localparam int          STATUS_W     = 2;
    localparam int          EVT_FLAG_SET = 0;
    localparam int          EVT_BUS_ERR  = 1;
    localparam logic [1:0]  RESET_STATUS = 2'h0;

    // ************************************************************
    // field layouts, bit 15 first
    // ************************************************************
    typedef struct packed {
        logic [1:0] unused_15_14;
        logic capture9_pending;    logic compare9_pending;
        logic spi3_event_pending;  logic spi3_fault_pending;
        logic uart4_tx_pending;    logic uart4_rx_pending;
        logic uart4_err_pending;   logic unused_6;
        logic i2c3_master_pending; logic i2c3_slave_pending;
        logic uart3_tx_pending;    logic uart3_rx_pending;
        logic uart3_err_pending;   logic unused_0;
    } flag5_t;

    typedef struct packed {
        logic [1:0] unused_15_14;
        logic adc_done_allow;  logic uart1_tx_allow;   logic uart1_rx_allow;
        logic spi1_done_allow; logic spi1_fault_allow; logic timer3_allow;
        logic timer2_allow;    logic compare2_allow;   logic capture2_allow;
        logic unused_4;        logic timer1_allow;     logic compare1_allow;
        logic capture1_allow;  logic ext_pin0_allow;
    } enable0_t;

    typedef struct packed {
        logic uart2_tx_allow;  logic uart2_rx_allow;   logic ext_pin2_allow;
        logic timer5_allow;    logic timer4_allow;     logic compare4_allow;
        logic compare3_allow;  logic unused_8;         logic capture8_allow;
        logic capture7_allow;  logic unused_5;         logic ext_pin1_allow;
        logic pin_change_allow; logic comparator_allow;
        logic i2c1_master_allow; logic i2c1_slave_allow;
    } enable1_t;

    typedef struct packed {
        logic [1:0] unused_15_14;
        logic parallel_port_allow;
        logic compare8_allow;  logic compare7_allow;
        logic compare6_allow;  logic compare5_allow;
        logic capture6_allow;  logic capture5_allow;
        logic capture4_allow;  logic capture3_allow;
        logic [2:0] unused_4_2;
        logic spi2_event_allow; logic spi2_fault_allow;
    } enable2_t;

endpackage : irq_bank_pkg

// ===== logic/interrupt_flag_enable_bank.sv
// interrupt_flag_enable_bank: fifth pending flag register, first three
// enable registers, request gating and a small event/interrupt block.
// assumes: apb master on clk, peripheral set strobes synchronous to clk,
// flag registers 0..2 and enable register 5 live outside and arrive as inputs.
//
// How it works
// RULE1: flag5 bit 13 holds capture 9 pending, bit 12 compare 9 pending.
// RULE2: flag5 bit 11 holds spi3 event pending, bit 10 spi3 fault pending.
// RULE3: flag5 bits 9, 8, 7 hold uart4 transmit, receive, error pending.
// RULE4: flag5 bit 5 i2c3 master, bit 4 i2c3 slave; bit 6 absent.
// RULE5: flag5 bits 3, 2, 1 hold uart3 transmit, receive, error; bit 0 absent.
// RULE6: a flag reads one after its source requested; software reads/writes; resets zero.
// RULE7: absent bit positions read zero and ignore writes.
// RULE8: enable one lets the source request through, zero blocks; writable, resets zero.
// RULE9: enable0 bits 13..8: adc, uart1 tx/rx, spi1 done/fault, timer3.
// RULE10: enable0 bits 7..5 timer2, compare2, capture2; 3..0 timer1, compare1, capture1, pin0.
// RULE11: enable1 bits 15..9 uart2 tx/rx, pin2, timer5, timer4, compare4, compare3.
// RULE12: enable1 bits 7,6 capture8/7; 4 pin1; 3 change; 2 comparator; 1,0 i2c1.
// RULE13: software enabling an external pin must also route it to a remappable pin.
// RULE14: enable2 bit 13 parallel port, 12..9 compare8..5, 8..5 capture6..3, 1..0 spi2.
// RULE15: a request reaches priority logic only while its flag and enable are both one; the gate is registered, so a request lags them by one cycle.
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/10ps
`default_nettype none

module interrupt_flag_enable_bank
    import irq_bank_pkg::*;
#(
    parameter int ADDR_W = 8
) (
    // clock and reset
    input  wire logic              clk,
    input  wire logic              rst_n,
    // apb slave
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [31:0]       prdata,
    output logic                   pready,
    output logic                   pslverr,
    // peripheral set strobes for the fifth flag register
    input  wire flag5_t            flag5_set,
    // enables of the fifth register's sources, held elsewhere
    input  wire flag5_t            flag5_allow,
    // pending flags of the enabled sources, held elsewhere
    input  wire enable0_t          pending0,
    input  wire enable1_t          pending1,
    input  wire enable2_t          pending2,
    // register contents toward the interrupt core
    output flag5_t                 flag5,
    output enable0_t               allow0,
    output enable1_t               allow1,
    output enable2_t               allow2,
    // gated requests toward the priority logic
    output flag5_t                 request5,
    output enable0_t               request0,
    output enable1_t               request1,
    output enable2_t               request2,
    // bank interrupt
    output logic                   irq
);

    // ************************************************************
    // bus decode
    // ************************************************************
    logic                answer;
    logic                done;
    logic [15:0]         lane_mask;
    logic [15:0]         wr_data;
    logic                sel_flag5;
    logic                sel_en0;
    logic                sel_en1;
    logic                sel_en2;
    logic                sel_status;
    logic                sel_mask;
    logic                sel_req5;
    logic                hit;
    logic [31:0]         rd_mux;
    logic [STATUS_W-1:0] status;
    logic [STATUS_W-1:0] mask;
    logic [STATUS_W-1:0] events;
    logic [STATUS_W-1:0] next_status;
    flag5_t              next_flag5;

    // access phase waiting for its answer, and the completing edge
    assign answer = psel & penable & ~pready;
    assign done   = psel & penable & pready;

    // byte lanes 0 and 1 carry the 16-bit registers
    assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    assign wr_data   = pwdata[15:0] & lane_mask;

    // register select from the word address
    always_comb begin
        sel_flag5  = 1'b0;
        sel_en0    = 1'b0;
        sel_en1    = 1'b0;
        sel_en2    = 1'b0;
        sel_status = 1'b0;
        sel_mask   = 1'b0;
        sel_req5   = 1'b0;
        unique case ({paddr[7:2], 2'b00})
            OFS_FLAG5:      sel_flag5  = 1'b1;
            OFS_ENABLE0:    sel_en0    = 1'b1;
            OFS_ENABLE1:    sel_en1    = 1'b1;
            OFS_ENABLE2:    sel_en2    = 1'b1;
            OFS_IRQ_STATUS: sel_status = 1'b1;
            OFS_IRQ_MASK:   sel_mask   = 1'b1;
            OFS_REQUEST5:   sel_req5   = 1'b1;
            default: ;
        endcase
    end

    // unaligned or out-of-window addresses miss
    assign hit = (paddr[1:0] == 2'b00) && (ADDR_W == 8 || paddr[ADDR_W-1:0] < ADDR_W'(256))
               && (sel_flag5 | sel_en0 | sel_en1 | sel_en2 | sel_status | sel_mask | sel_req5);

    // read data, absent bits forced to zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (sel_flag5) begin
            rd_mux[15:0] = flag5 & IMPL_FLAG5;     // RULE7
        end else if (sel_en0) begin
            rd_mux[15:0] = allow0 & IMPL_ENABLE0;  // RULE7
        end else if (sel_en1) begin
            rd_mux[15:0] = allow1 & IMPL_ENABLE1;  // RULE7
        end else if (sel_en2) begin
            rd_mux[15:0] = allow2 & IMPL_ENABLE2;  // RULE7
        end else if (sel_status) begin
            rd_mux[STATUS_W-1:0] = status;
        end else if (sel_mask) begin
            rd_mux[STATUS_W-1:0] = mask;
        end else if (sel_req5) begin
            rd_mux[15:0] = request5;
        end
    end

    // ************************************************************
    // apb answer: one wait state, all outputs registered
    // ************************************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0000_0000;
        end else begin
            pready  <= answer;
            pslverr <= answer & ~hit;
            if (answer && !pwrite && hit) begin
                prdata <= rd_mux;
            end else if (answer) begin
                prdata <= 32'h0000_0000;
            end
        end
    end

    // ************************************************************
    // fifth flag register
    // ************************************************************
    // software write first, then peripheral sets win over a clearing write
    always_comb begin
        next_flag5 = flag5;
        if (done && pwrite && hit && sel_flag5) begin
            next_flag5 = (flag5 & ~lane_mask) | wr_data;           // RULE6
        end
        next_flag5 = next_flag5 | flag5_set;                       // RULE6
        next_flag5 = next_flag5 & IMPL_FLAG5;                      // RULE7
    end

    // named set strobes land on their documented positions
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag5 <= RESET_REG16;                                  // RULE6
        end else begin
            flag5 <= next_flag5;
            flag5.capture9_pending    <= next_flag5.capture9_pending;    // RULE1
            flag5.compare9_pending    <= next_flag5.compare9_pending;    // RULE1
            flag5.spi3_event_pending  <= next_flag5.spi3_event_pending;  // RULE2
            flag5.spi3_fault_pending  <= next_flag5.spi3_fault_pending;  // RULE2
            flag5.uart4_tx_pending    <= next_flag5.uart4_tx_pending;    // RULE3
            flag5.uart4_rx_pending    <= next_flag5.uart4_rx_pending;    // RULE3
            flag5.uart4_err_pending   <= next_flag5.uart4_err_pending;   // RULE3
            flag5.i2c3_master_pending <= next_flag5.i2c3_master_pending; // RULE4
            flag5.i2c3_slave_pending  <= next_flag5.i2c3_slave_pending;  // RULE4
            flag5.uart3_tx_pending    <= next_flag5.uart3_tx_pending;    // RULE5
            flag5.uart3_rx_pending    <= next_flag5.uart3_rx_pending;    // RULE5
            flag5.uart3_err_pending   <= next_flag5.uart3_err_pending;   // RULE5
        end
    end

    // ************************************************************
    // enable registers
    // ************************************************************
    // software-owned, byte-lane writes, absent bits held at zero
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            allow0 <= RESET_REG16;                                 // RULE8
            allow1 <= RESET_REG16;                                 // RULE8
            allow2 <= RESET_REG16;                                 // RULE8
        end else if (done && pwrite && hit) begin
            if (sel_en0) begin
                allow0 <= ((allow0 & ~lane_mask) | wr_data) & IMPL_ENABLE0; // RULE9 RULE10
            end
            if (sel_en1) begin
                allow1 <= ((allow1 & ~lane_mask) | wr_data) & IMPL_ENABLE1; // RULE11 RULE12
            end
            if (sel_en2) begin
                allow2 <= ((allow2 & ~lane_mask) | wr_data) & IMPL_ENABLE2; // RULE14
            end
        end
    end

    // ************************************************************
    // gated requests toward the priority logic
    // ************************************************************
    // external pin enables are passed as they are; pin routing is software's job
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            request5 <= RESET_REG16;
            request0 <= RESET_REG16;
            request1 <= RESET_REG16;
            request2 <= RESET_REG16;
        end else begin
            request5 <= flag5 & flag5_allow & IMPL_FLAG5;          // RULE15
            request0 <= pending0 & allow0;                         // RULE15 RULE8 RULE13
            request1 <= pending1 & allow1;                         // RULE15 RULE8 RULE13
            request2 <= pending2 & allow2;                         // RULE15 RULE8
        end
    end

    // ************************************************************
    // bank events, mask and interrupt
    // ************************************************************
    assign events[EVT_FLAG_SET] = |(flag5_set & IMPL_FLAG5 & ~flag5);
    assign events[EVT_BUS_ERR]  = done & ~hit;

    // read clears only the bits returned; a new event wins over the clear
    always_comb begin
        next_status = status;
        if (done && !pwrite && hit && sel_status) begin
            next_status = status & ~prdata[STATUS_W-1:0];
        end
        next_status = next_status | events;
    end

    // status, mask and level interrupt
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            status <= RESET_STATUS;
            mask   <= RESET_STATUS;
            irq    <= 1'b0;
        end else begin
            status <= next_status;
            if (done && pwrite && hit && sel_mask && pstrb[0]) begin
                mask <= pwdata[STATUS_W-1:0];
            end
            irq <= |(next_status & mask);
        end
    end

endmodule : interrupt_flag_enable_bank

`default_nettype wire

// ===== testbench/bank_monitor.sv
// checker for the flag and enable bank, top-level ports only
// assumes: one clock domain, apb slave with one wait state
`timescale 1ns/10ps
`default_nettype none
module bank_monitor
    import irq_bank_pkg::*;
(
    // clock and reset
    input wire logic        clk,
    input wire logic        rst_n,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // bank contents
    input wire flag5_t      flag5_set,
    input wire flag5_t      flag5_allow,
    input wire enable0_t    pending0,
    input wire flag5_t      flag5,
    input wire enable0_t    allow0,
    input wire enable2_t    allow2,
    input wire flag5_t      request5,
    input wire enable0_t    request0
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // ****
    // apb phases
    // ****
    sequence setup_s;
        psel && !penable;
    endsequence
    sequence wait_s;
        psel && penable && !pready;
    endsequence
    pready_wait_a: assert property (setup_s ##1 wait_s |=> pready) else $error("pready late");
    pready_pulse_a: assert property (pready |=> !pready) else $error("pready too long");
    error_data_a: assert property (pready && pslverr |-> prdata == 32'h0000_0000) else $error("error data");
    upper_zero_a: assert property (pready |-> prdata[31:16] == 16'h0000) else $error("upper half");
    // ****
    // flags, enables, requests
    // ****
    flag_set_a: assert property ((flag5_set & IMPL_FLAG5) != 16'h0000 |=>
        (flag5 & $past(flag5_set) & IMPL_FLAG5) == ($past(flag5_set) & IMPL_FLAG5)) else $error("flag lost");
    unused_zero_a: assert property ((flag5 & ~IMPL_FLAG5) == 16'h0000 &&
        (allow0 & ~IMPL_ENABLE0) == 16'h0000 && (allow2 & ~IMPL_ENABLE2) == 16'h0000) else $error("absent bit");
    enable_hold_a: assert property (!(psel && penable && pready && pwrite) |=> $stable(allow0))
        else $error("enable moved");
    gate_flag5_a: assert property (request5 == ($past(flag5) & $past(flag5_allow)))
        else $error("request5 gate");
    gate_en0_a: assert property (request0 == ($past(pending0) & $past(allow0)))
        else $error("request0 gate");
endmodule : bank_monitor
bind interrupt_flag_enable_bank bank_monitor mon (.clk(clk), .rst_n(rst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flag5_set(flag5_set), .flag5_allow(flag5_allow), .pending0(pending0), .flag5(flag5),
    .allow0(allow0), .allow2(allow2), .request5(request5), .request0(request0));
`default_nettype wire

// ===== testbench/periph_model.sv
// peripheral source model: one-cycle set strobes and held levels
// assumes: bench changes fire and level right after rising edges
`timescale 1ns/10ps
`default_nettype none
module periph_model
    import irq_bank_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // bench requests
    input  wire flag5_t      fire,
    input  wire logic [63:0] level,
    // toward the bank
    output flag5_t           flag5_set,
    output flag5_t           flag5_allow,
    output enable0_t         pending0,
    output enable1_t         pending1,
    output enable2_t         pending2
);
    // strobe per event, external pins arrive already routed
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            flag5_set <= 16'h0000;
            {flag5_allow, pending0, pending1, pending2} <= 64'h0000_0000_0000_0000;
        end else begin
            flag5_set <= fire;
            {flag5_allow, pending0, pending1, pending2} <= level;
        end
    end
endmodule : periph_model
`default_nettype wire

// ===== testbench/test_interrupt_flag_enable_bank.sv
// self-checking bench for the flag and enable bank
// assumes: package compiled first, monitor bound to the dut
`timescale 1ns/10ps
`default_nettype none
module test_interrupt_flag_enable_bank
    import irq_bank_pkg::*;
;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata, rd;
    logic        pready, pslverr, irq, err;
    flag5_t      fire = 16'h0000;
    logic [63:0] level = 64'h0000_0000_0000_0000;
    flag5_t      flag5_set, flag5_allow, flag5, request5;
    enable0_t    pending0, allow0, request0;
    enable1_t    pending1, allow1, request1;
    enable2_t    pending2, allow2, request2;
    int          num_errors = 0;
    int          check_count = 0;

    always #50 clk = ~clk;

    interrupt_flag_enable_bank dut (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'h3), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .flag5_set(flag5_set), .flag5_allow(flag5_allow),
        .pending0(pending0), .pending1(pending1), .pending2(pending2), .flag5(flag5),
        .allow0(allow0), .allow1(allow1), .allow2(allow2), .request5(request5),
        .request0(request0), .request1(request1), .request2(request2), .irq(irq));
    periph_model model (.clk(clk), .rst_n(rst_n), .fire(fire), .level(level),
        .flag5_set(flag5_set), .flag5_allow(flag5_allow), .pending0(pending0),
        .pending1(pending1), .pending2(pending2));

    // ****
    // helpers
    // ****
    function automatic logic [31:0] expect_rd(input logic [15:0] v, input logic [15:0] m);
        return {16'h0000, v & m};
    endfunction : expect_rd

    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            num_errors++;
            wrap_up();
        end
        @(posedge clk);
    endtask : apb

    task automatic pulse(input flag5_t f);
        fire <= f;
        @(posedge clk);
        fire <= 16'h0000;
        repeat (3) @(posedge clk);
    endtask : pulse

    // ****
    // main sequence
    // ****
    initial begin
        logic [15:0] impl [4];
        logic [15:0] v;
        impl = '{IMPL_FLAG5, IMPL_ENABLE0, IMPL_ENABLE1, IMPL_ENABLE2};
        v = 16'($urandom(32'hfff1));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        // reset value, all ones, random value per register
        for (int i = 0; i < 4; i++) begin
            apb(1'b0, 8'(4 * i), 32'h0000_0000);
            chk(rd, 32'h0000_0000);
            apb(1'b1, 8'(4 * i), 32'hFFFF_FFFF);
            apb(1'b0, 8'(4 * i), 32'h0000_0000);
            chk(rd, expect_rd(16'hFFFF, impl[i]));
            v = 16'($urandom);
            apb(1'b1, 8'(4 * i), {16'hFFFF, v});
            apb(1'b0, 8'(4 * i), 32'h0000_0000);
            chk(rd, expect_rd(v, impl[i]));
        end
        // single enable fields
        apb(1'b1, OFS_ENABLE0, 32'h0000_2001);
        chk({30'h0, allow0.adc_done_allow, allow0.ext_pin0_allow}, 32'h0000_0003);
        apb(1'b1, OFS_ENABLE1, 32'h0000_8008);
        chk({30'h0, allow1.uart2_tx_allow, allow1.pin_change_allow}, 32'h0000_0003);
        apb(1'b1, OFS_ENABLE2, 32'h0000_1000);
        chk({31'h0, allow2.compare8_allow}, 32'h0000_0001);
        // every source strobe lands on its own bit, mask off
        apb(1'b1, OFS_FLAG5, 32'h0000_0000);
        for (int b = 0; b < 16; b++) begin
            pulse(flag5_t'(16'h0001 << b));
            chk({31'h0, irq}, 32'h0000_0000);
            apb(1'b0, OFS_FLAG5, 32'h0000_0000);
            chk(rd, expect_rd(16'h0001 << b, IMPL_FLAG5));
            apb(1'b1, OFS_FLAG5, 32'h0000_0000);
        end
        // interrupt raised, read clears it
        apb(1'b0, OFS_IRQ_STATUS, 32'h0000_0000);
        apb(1'b1, OFS_IRQ_MASK, 32'h0000_0001);
        apb(1'b0, OFS_IRQ_MASK, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        pulse(16'h2000);
        chk({31'h0, irq}, 32'h0000_0001);
        apb(1'b0, OFS_IRQ_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0000);
        // unmapped address refused, logged as bus error
        apb(1'b1, 8'h1C, 32'hFFFF_FFFF);
        chk({31'h0, err}, 32'h0000_0001);
        apb(1'b0, OFS_IRQ_STATUS, 32'h0000_0000);
        chk(rd, 32'h0000_0002);
        // unaligned address refused as well
        apb(1'b0, 8'h05, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001);
        chk(rd, 32'h0000_0000);
        // random gating of flags and enables
        for (int k = 0; k < 8; k++) begin
            level <= {$urandom, $urandom};
            v = 16'($urandom);
            apb(1'b1, OFS_ENABLE0, {16'h0000, v});
            apb(1'b1, OFS_FLAG5, {16'h0000, ~v});
            repeat (2) @(posedge clk);
            chk({16'h0, request0}, expect_rd(level[47:32] & v, IMPL_ENABLE0));
            chk({16'h0, request5}, expect_rd(level[63:48] & ~v, IMPL_FLAG5));
            chk({16'h0, request1}, expect_rd(level[31:16], 16'h8008));
            chk({16'h0, request2}, expect_rd(level[15:0], 16'h1000));
            apb(1'b0, OFS_REQUEST5, 32'h0000_0000);
            chk(rd, expect_rd(level[63:48] & ~v, IMPL_FLAG5));
        end
        // second reset in mid-run
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, OFS_ENABLE0, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        wrap_up();
    end
endmodule : test_interrupt_flag_enable_bank
`default_nettype wire
